// *** logic/wls_pkg.sv ***
// Types of the wind limit value output scheduler.
package wls_pkg;
  typedef enum logic [1:0] {
    WLS_ACT_OFF = 2'h0,
    WLS_ACT_ON = 2'h1,
    WLS_ACT_NONE = 2'h2
  } wls_act_e;
  typedef logic [3:0] wls_dly_t;
  // Delay table index 0 is no delay; steps from 1 s to 60 min.
  function automatic logic [11:0] wls_dly_secs(input wls_dly_t sel);
    case (sel)
      4'h0: wls_dly_secs = 12'h000;
      4'h1: wls_dly_secs = 12'h001;
      4'h2: wls_dly_secs = 12'h003;
      4'h3: wls_dly_secs = 12'h005;
      4'h4: wls_dly_secs = 12'h00A;
      4'h5: wls_dly_secs = 12'h00F;
      4'h6: wls_dly_secs = 12'h01E;
      4'h7: wls_dly_secs = 12'h03C;
      4'h8: wls_dly_secs = 12'h0B4;
      4'h9: wls_dly_secs = 12'h12C;
      4'hA: wls_dly_secs = 12'h258;
      4'hB: wls_dly_secs = 12'h384;
      4'hC: wls_dly_secs = 12'h708;
      default: wls_dly_secs = 12'hE10;
    endcase
  endfunction
endpackage

// *** logic/wls_regs.svh ***
// Constants of the wind limit value output scheduler.
`ifndef WLS_REGS_SVH
`define WLS_REGS_SVH
`define WLS_CLK_HZ 20000000
`define WLS_TICK_CYC (`WLS_CLK_HZ)
`define WLS_CYCLIC_STEP_S 10
`define WLS_CYCLIC_MAX 120
`define WLS_LV2_DEFAULT 8'h0A
`define WLS_LV2_MIN 8'h01
`define WLS_LV2_MAX 8'h23
`define WLS_HYST_DEFAULT 8'h03
`define WLS_ON_DLY_DEFAULT 4'h8
`define WLS_OFF_DLY_DEFAULT 4'hA
`endif

// *** logic/wls_scheduler.sv ***
// Limit value state, delays and telegram scheduling for one wind channel.
`timescale 1ns/1ns
`include "wls_regs.svh"
module wls_scheduler
  import wls_pkg::*;
#(
  parameter int TICK_CYC = `WLS_TICK_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Measurement and threshold settings, in m/s.
  input wire logic [7:0] windSpeed,
  input wire logic [7:0] thresholdLevel,
  input wire logic [7:0] hysteresis,
  input wire logic inverseSense,
  input wire logic [1:0] actExceed,
  input wire logic [1:0] actUndershoot,
  // Delay and send settings.
  input wire logic [3:0] onDelaySel,
  input wire logic [3:0] offDelaySel,
  input wire logic sendOnChange,
  input wire logic [6:0] cyclicCount,
  // Telegram request to the bus interface and the applied limit state.
  output logic sendReq,
  output logic sendValue,
  output logic limitState
);
  logic [24:0] tickCnt_q;
  logic tick_q;
  logic rawState_q;
  logic crossVal_q;
  logic crossSilent_q;
  logic [11:0] dlyCnt_q;
  logic dlyRun_q;
  logic [10:0] cycCnt_q;
  logic sendReq_q;
  logic sendValue_q;
  logic outState_q;

  // Limit clamped to the 1..35 m/s range of the second limit.
  wire logic [7:0] lvClamped = (thresholdLevel < `WLS_LV2_MIN) ?
    `WLS_LV2_MIN : (thresholdLevel > `WLS_LV2_MAX) ?
    `WLS_LV2_MAX : thresholdLevel;
  wire logic [8:0] hiLimit = {1'b0, lvClamped} + {1'b0, hysteresis};
  wire logic [8:0] loLimit = {1'b0, lvClamped} - {1'b0, hysteresis};
  // Normal sense: exceed at LV, release below LV - hysteresis.
  // Inverse sense: undershoot at LV, release above LV + hysteresis.
  wire logic hitUp = inverseSense ? ({1'b0, windSpeed} < {1'b0, lvClamped})
                                  : (windSpeed > lvClamped);
  wire logic hitDn = inverseSense ? ({1'b0, windSpeed} > hiLimit)
                                  : (loLimit[8] ? 1'b0 :
                                     ({1'b0, windSpeed} < loLimit));
  wire logic setEvt = hitUp && !rawState_q;
  wire logic clrEvt = hitDn && rawState_q;
  wire logic [1:0] evtAct = setEvt ? actExceed : actUndershoot;
  wire logic evtNone = (evtAct == 2'(WLS_ACT_NONE)) ||
                       (evtAct == 2'h3);
  wire logic evtVal = (evtAct == 2'(WLS_ACT_ON));
  wire logic crossEvt = (setEvt || clrEvt) && !evtNone;
  wire logic pending = crossVal_q != outState_q;
  wire logic dlyDone = pending && dlyRun_q && (dlyCnt_q == 12'h000);
  wire logic [10:0] cycPeriod = 11'(cyclicCount) * 11'(`WLS_CYCLIC_STEP_S);
  wire logic cycDue = (cyclicCount != 7'h00) && tick_q &&
                      (cycCnt_q >= cycPeriod - 11'h001);

  // Seconds tick from the core clock.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_q <= 25'h0000000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tickCnt_q == 25'(TICK_CYC - 1));
      tickCnt_q <= (tickCnt_q == 25'(TICK_CYC - 1)) ? 25'h0000000
                                                    : tickCnt_q + 25'h1;
    end
  end

  // Hysteresis state and the value requested by the last crossing.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rawState_q <= 1'b0;
      crossVal_q <= 1'b0;
      crossSilent_q <= 1'b0;
    end else begin
      if (setEvt) begin
        rawState_q <= 1'b1;
      end else if (clrEvt) begin
        rawState_q <= 1'b0;
      end
      if (setEvt || clrEvt) begin
        crossSilent_q <= evtNone;
        if (!evtNone) begin
          crossVal_q <= evtVal;
        end
      end
    end
  end

  // Delay timer; a new crossing with an on or off action restarts it, the old value stays meanwhile.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dlyCnt_q <= 12'h000;
      dlyRun_q <= 1'b0;
      outState_q <= 1'b0;
    end else if (crossEvt) begin
      dlyCnt_q <= evtVal ? wls_dly_secs(onDelaySel)
                         : wls_dly_secs(offDelaySel);
      dlyRun_q <= 1'b1;
    end else if (dlyDone) begin
      outState_q <= crossVal_q;
      dlyRun_q <= 1'b0;
    end else if (dlyRun_q && tick_q && dlyCnt_q != 12'h000) begin
      dlyCnt_q <= dlyCnt_q - 12'h001;
    end
  end

  // Cyclic repeat counter in seconds and the telegram request.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cycCnt_q <= 11'h000;
      sendReq_q <= 1'b0;
      sendValue_q <= 1'b0;
    end else begin
      if (cycDue || cyclicCount == 7'h00) begin
        cycCnt_q <= 11'h000;
      end else if (tick_q) begin
        cycCnt_q <= cycCnt_q + 11'h001;
      end
      sendReq_q <= 1'b0;
      if (dlyDone && sendOnChange) begin
        sendReq_q <= 1'b1;
        sendValue_q <= crossVal_q;
      end else if (cycDue && !crossSilent_q) begin
        // The old value repeats while a delay is pending; on the apply
        // cycle the new value goes out so it matches the output object.
        sendReq_q <= 1'b1;
        sendValue_q <= dlyDone ? crossVal_q : outState_q;
      end
    end
  end

  assign sendReq = sendReq_q;
  assign sendValue = sendValue_q;
  assign limitState = outState_q;
endmodule

// *** test/test_wls_scheduler.sv ***
// Self-checking bench for the limit output scheduler.
`timescale 1ns/1ns
module test_wls_scheduler;
  // Reset starts high so the first start() makes a real falling edge.
  logic core_clk = 1'b0, nrst = 1'b1, inverseSense = 1'b0;
  logic sendOnChange = 1'b0, sendReq, sendValue, limitState, rxValue;
  logic [7:0] windSpeed = 8'h00, thresholdLevel = 8'h0A, hysteresis = 8'h03;
  logic [1:0] actExceed = 2'h1, actUndershoot = 2'h0;
  logic [3:0] onDelaySel = 4'h0, offDelaySel = 4'h0;
  logic [6:0] cyclicCount = 7'h00;
  logic [15:0] rxCount, n;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  wls_scheduler #(.TICK_CYC(20)) u_wls_scheduler (.*);
  wls_bus_rx u_wls_bus_rx (.*);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin num_errors++; results(); end
  end
  function int sends(int c, int len); return len / (c * 200); endfunction
  function logic [7:0] hi; return 8'(37 + $urandom % 219); endfunction
  task chk(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task results;
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task go(input logic [7:0] w, input int len);
    windSpeed <= w;
    repeat (len) @(posedge core_clk);
  endtask
  // Each case starts from reset so no timer carries over.
  task start(input logic s, input logic [6:0] c, input logic [1:0] a,
             input logic [3:0] d1, d2);
    nrst <= 1'b0;
    go(8'h00, 3);
    nrst <= 1'b1; sendOnChange <= s; cyclicCount <= c; actExceed <= a;
    actUndershoot <= a ^ 2'h1; onDelaySel <= d1; offDelaySel <= d2;
    thresholdLevel <= 8'(10 + $urandom % 26);
    hysteresis <= 8'(1 + $urandom % 5);
  endtask
  initial begin
    void'($urandom(83418));
    start(1'b1, 7'h00, 2'h1, 4'h3, 4'h4);
    go(hi(), 70); chk(limitState, 16'h0);
    go(hi(), 60); chk(limitState, 16'h1); chk(rxCount, 16'h1);
    go(8'h00, 170); chk(limitState, 16'h1);
    go(8'h00, 60); chk(rxCount, 16'h2); chk(rxValue, 16'h0);
    start(1'b0, 7'h01, 2'h1, 4'h0, 4'h5);
    go(hi(), 1100); chk(rxCount, 16'(sends(1, 1100)));
    n = rxCount;
    go(8'h00, 250); chk(rxCount, n + 16'h1); chk(rxValue, 16'h1);
    start(1'b0, 7'h00, 2'h1, 4'h0, 4'h0);
    repeat (20) go(8'($urandom), 30);
    chk(rxCount, 16'h0);
    start(1'b1, 7'h01, 2'(2 + $urandom % 2), 4'h0, 4'h0);
    go(hi(), 500); chk(rxCount, 16'h0); chk(limitState, 16'h0);
    results();
  end
endmodule
bind wls_scheduler wls_scheduler_sva u_wls_scheduler_sva (.*);

// *** test/wls_bus_rx.sv ***
// Bus receiver model that counts limit telegrams and keeps the last value.
`timescale 1ns/1ns
module wls_bus_rx (
  // Clock, reset and telegram request.
  input logic core_clk,
  input logic nrst,
  input logic sendReq,
  input logic sendValue,
  // What the receiver has seen.
  output logic [15:0] rxCount,
  output logic rxValue
);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxCount <= 16'h0000;
      rxValue <= 1'b0;
    end else if (sendReq) begin
      rxCount <= rxCount + 16'h0001;
      rxValue <= sendValue;
    end
  end
endmodule

// *** test/wls_scheduler_sva.sv ***
// Concurrent checks on the ports of the limit output scheduler.
`timescale 1ns/1ns
module wls_scheduler_sva (
  // Clock, reset and settings.
  input logic core_clk, nrst, inverseSense, sendOnChange,
  input logic [7:0] windSpeed, thresholdLevel, hysteresis,
  input logic [1:0] actExceed, actUndershoot,
  input logic [3:0] onDelaySel, offDelaySel,
  input logic [6:0] cyclicCount,
  // Telegram side.
  input logic sendReq, sendValue, limitState
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Wind above 35 m/s exceeds any clamped threshold.
  sequence storm_s;
    (!inverseSense && actExceed == 2'h1 && onDelaySel == 4'h0
      && windSpeed > 8'h24) [*4];
  endsequence
  sequence mute_s;
    (actExceed[1] && actUndershoot[1] && onDelaySel == 4'h0
      && offDelaySel == 4'h0) [*4];
  endsequence
  change_send_a: assert property ($changed(limitState) && sendOnChange
    |-> sendReq && sendValue == limitState) else $error("change lost");
  quiet_off_a: assert property ((!sendOnChange && cyclicCount == 7'h00)
    [*3] |-> !sendReq) else $error("telegram while disabled");
  value_pair_a: assert property (sendReq |-> sendValue == limitState)
    else $error("telegram value wrong");
  value_hold_a: assert property ($changed(sendValue) |-> sendReq)
    else $error("value moved alone");
  cyclic_period_a: assert property (sendReq && cyclicCount == 7'h01
    && !sendOnChange |-> ##[199:201] sendReq) else $error("cycle late");
  reset_clear_a: assert property (disable iff (1'b0) !nrst
    |-> !sendReq && !limitState) else $error("reset not clear");
  none_hold_a: assert property (mute_s |-> $stable(limitState))
    else $error("state moved on no telegram");
  exceed_set_a: assert property (storm_s |-> limitState)
    else $error("exceed not applied");
endmodule
